// File: core/ptv_pkg.sv
// Shared constants and helpers for the protective channel trip voter
`default_nettype none
package ptv_pkg;
  // Channel count and local index
  localparam int          CHANNELS      = 4;
  localparam logic [2:0]  VOTE_MIN      = 3'h2;  // Two of four
  localparam logic [2:0]  SEL_MIN_VALID = 3'h2;  // Second-order selection needs two
  localparam logic [3:0]  LOCAL_MASK    = 4'h1;
  localparam logic [3:0]  PEER_MASK     = 4'he;  // Local input never loses a link
  // Coolant pumps per loop
  localparam logic [3:0]  LOOP_A_PUMPS  = 4'h3;
  localparam logic [3:0]  LOOP_B_PUMPS  = 4'hc;
  // Feedwater contact layout: four channel copies per pump turbine
  localparam int          FW_PUMP1_LSB  = 0;
  localparam int          FW_PUMP2_LSB  = 4;
  // Alarm bit positions
  localparam int          ALM_TRIP      = 0;
  localparam int          ALM_TROUBLE   = 1;
  localparam int          ALM_TEST      = 2;
  localparam int          ALM_FLUX_PSU  = 3;
  localparam int          ALM_SD_BYP    = 4;
  localparam int          ALM_MAN_BYP   = 5;
  localparam int          ALM_W         = 6;
  // Service link selects
  localparam logic [1:0]  SVC_STATUS    = 2'h0;
  localparam logic [1:0]  SVC_TEMP      = 2'h1;
  localparam logic [1:0]  SVC_PRESS     = 2'h2;
  localparam logic [1:0]  SVC_PUMP      = 2'h3;
  // Plant computer status word width
  localparam int          STAT_W        = 16;

  // Number of set bits in a four bit group
  function automatic logic [2:0] ones4(input logic [3:0] x);
    ones4 = 3'(x[0]) + 3'(x[1]) + 3'(x[2]) + 3'(x[3]);
  endfunction
endpackage
`default_nettype wire

// File: core/ptv_sel_if.sv
// Interface between the channel logic and a signal selector
`default_nettype none
interface ptv_sel_if #(parameter int W = 16);
  logic [3:0][W-1:0] val;
  logic [3:0]        valid;
  logic [W-1:0]      max2;
  logic [W-1:0]      min2;
  logic              ok;
  modport src (output val, output valid, input max2, input min2, input ok);
  modport sel (input val, input valid, output max2, output min2, output ok);
endinterface
`default_nettype wire

// File: core/ptv_select.sv
// Second-maximum and second-minimum selector over valid inputs
`default_nettype none
module ptv_select (
  // Selection bus
  ptv_sel_if.sel bus
);
  logic [2:0] cnt;
  logic [2:0] target;
  logic [2:0] rank_hi;
  logic [2:0] rank_lo;

  // Fewer than two valid inputs: the lone survivor passes straight through
  assign cnt    = ptv_pkg::ones4(bus.valid);
  assign target = (cnt >= ptv_pkg::SEL_MIN_VALID) ? 3'h1 : 3'h0;
  assign bus.ok = (cnt != 3'h0);

  // Rank each valid input; ties broken by index so exactly one wins
  always_comb begin
    rank_hi  = 3'h0;
    rank_lo  = 3'h0;
    bus.max2 = '0;
    bus.min2 = '0;
    for (int i = 0; i < ptv_pkg::CHANNELS; i++) begin
      rank_hi = 3'h0;
      rank_lo = 3'h0;
      for (int j = 0; j < ptv_pkg::CHANNELS; j++) begin
        if (j != i && bus.valid[j]) begin
          if (bus.val[j] > bus.val[i] || (bus.val[j] == bus.val[i] && j < i)) begin
            rank_hi = rank_hi + 3'h1;
          end
          if (bus.val[j] < bus.val[i] || (bus.val[j] == bus.val[i] && j < i)) begin
            rank_lo = rank_lo + 3'h1;
          end
        end
      end
      // Faulted inputs never take part
      if (bus.valid[i] && rank_hi == target) begin
        bus.max2 = bus.val[i];
      end
      if (bus.valid[i] && rank_lo == target) begin
        bus.min2 = bus.val[i];
      end
    end
  end
endmodule
`default_nettype wire

// File: core/ptv_channel.sv
// Trip decision, 2-of-4 voter and annunciation for one protective channel
// Behaviour
// - One stopped-pump status bit per pump arrives at this channel.
// - Count running coolant pumps and flag which loops have pumps running.
// - Outlet temperature trips when second-maximum element exceeds its setpoint.
// - Two or more channels in trip assert the voter trip output.
// - Trip when selected pressure or temperature leaves the combined boundary.
// - Trip when second-max pressure is high or second-min pressure low.
// - Enabled turbine trip fires when two of four hydraulic contacts open.
// - Own turbine contact state is shared out to the peer channels.
// - Enabled feedwater trip fires only when both pump turbines are tripped.
// - Turbine and feedwater trips are suppressed below startup flux threshold.
// - Building pressure trips on two of four open contacts, never one.
// - Exactly one open building contact raises trouble and reports it.
// - Six alarm outputs: trip, trouble, test, supply, shutdown and manual bypass.
// - Any test switch out of operate lights the on-test alarm.
// - Voter holds one relay per channel: own trip plus three peers.
// - Voter output drives this channel's rod drive breaker.
// - Failed peer input counts as cannot-trip or tripped, per fault mode.
// - One-way plant computer data, two-way service link, isolated status out.
// - Faulted or link-lost inputs are excluded; a lone valid input passes.
// - Selection works with two valid inputs; contact vote becomes 2-of-3.
// - Rod power is removed for breakers AB, AD, BC or CD open.
`default_nettype none
module ptv_channel #(
  parameter int W      = 16,
  parameter int TEST_N = 4
) (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                reset_i,
  // Analog inputs, index 0 local, 1..3 peers
  input  wire logic [3:0][W-1:0]   temp_val_i,
  input  wire logic [3:0]          temp_fault_i,
  input  wire logic [3:0][W-1:0]   press_val_i,
  input  wire logic [3:0]          press_fault_i,
  input  wire logic [3:0]          link_lost_i,
  input  wire logic [W-1:0]        flux_i,
  // Setpoints and enables
  input  wire logic [W-1:0]        temp_hi_sp_i,
  input  wire logic [W-1:0]        press_hi_sp_i,
  input  wire logic [W-1:0]        press_lo_sp_i,
  input  wire logic [W-1:0]        pt_bias_sp_i,
  input  wire logic [W-1:0]        flux_startup_sp_i,
  input  wire logic [2:0]          pump_min_i,
  input  wire logic                turb_enable_i,
  input  wire logic                fw_enable_i,
  // Contact inputs, 1 = open
  input  wire logic [3:0]          pump_stop_i,
  input  wire logic [3:0]          turb_open_i,
  input  wire logic [7:0]          fw_open_i,
  input  wire logic [3:0]          bldg_open_i,
  // Peer trips and voter fault handling
  input  wire logic [2:0]          peer_trip_i,
  input  wire logic [2:0]          peer_fault_i,
  input  wire logic                fault_as_trip_i,
  input  wire logic [3:0]          breaker_open_i,
  // Annunciation sources
  input  wire logic [TEST_N-1:0]   test_switch_i,
  input  wire logic                flux_psu_fail_i,
  input  wire logic                shutdown_bypass_i,
  input  wire logic                manual_bypass_i,
  // Service link
  input  wire logic                service_valid_i,
  input  wire logic                service_write_i,
  input  wire logic [1:0]          service_sel_i,
  input  wire logic                service_wdata_i,
  output logic                     service_ack_o,
  output logic [2*W-1:0]           service_data_o,
  // Shared to peers
  output logic                     channel_trip_o,
  output logic                     turb_share_o,
  output logic [1:0]               fw_share_o,
  // Voter and breakers
  output logic                     trip_relay_output_o,
  output logic                     rod_drive_breaker_trip_o,
  output logic                     rod_power_removed_o,
  // Pump monitor
  output logic [2:0]               pump_count_o,
  output logic [1:0]               pump_loop_o,
  // Annunciation and outward data
  output logic [ptv_pkg::ALM_W-1:0]  alarm_o,
  output logic [ptv_pkg::STAT_W-1:0] plant_computer_o,
  output logic [ptv_pkg::ALM_W-1:0]  nonsafety_status_o
);
  ptv_sel_if #(.W(W)) temp_sel ();
  ptv_sel_if #(.W(W)) press_sel ();

  logic [3:0] contact_valid;
  logic [3:0] running;
  logic [2:0] run_cnt;
  logic       flux_low;
  logic       temp_cond, press_cond, pt_cond, pump_cond;
  logic       turb_cond, fw_cond, bldg_cond, bldg_single;
  logic [2:0] bldg_cnt;
  logic [3:0] relay;
  logic       vote;
  logic       any_fault;
  logic       temp_trip_reg, press_trip_reg, pt_trip_reg, pump_trip_reg;
  logic       turb_trip_reg, fw_trip_reg, bldg_trip_reg, chan_trip_reg;
  logic       svc_test_trip_reg;
  logic       trouble_reg;
  logic [W:0] pt_limit;

  // Selection inputs; link loss faults peer data only
  assign temp_sel.val    = temp_val_i;
  assign temp_sel.valid  = ~(temp_fault_i | (link_lost_i & ptv_pkg::PEER_MASK));
  assign press_sel.val   = press_val_i;
  assign press_sel.valid = ~(press_fault_i | (link_lost_i & ptv_pkg::PEER_MASK));
  assign contact_valid   = ~(link_lost_i & ptv_pkg::PEER_MASK);

  ptv_select u_temp_sel (
    .bus (temp_sel)
  );
  ptv_select u_press_sel (
    .bus (press_sel)
  );

  // Pump monitor
  assign running = ~pump_stop_i;
  assign run_cnt = ptv_pkg::ones4(running);

  // Analog trip conditions; no valid input at all fails safe to trip
  assign temp_cond  = !temp_sel.ok || (temp_sel.max2 > temp_hi_sp_i);
  assign press_cond = !press_sel.ok || (press_sel.max2 > press_hi_sp_i) ||
                      (press_sel.min2 < press_lo_sp_i);
  // Comparator edge: pressure must stay at or above temperature plus bias
  assign pt_limit   = {1'b0, temp_sel.max2} + {1'b0, pt_bias_sp_i};
  assign pt_cond    = temp_cond || press_cond ||
                      ({1'b0, press_sel.min2} < pt_limit);
  assign pump_cond  = (run_cnt < pump_min_i);

  // Contact votes among inputs still valid
  assign flux_low  = (flux_i < flux_startup_sp_i);
  assign turb_cond = turb_enable_i && !flux_low &&
                     (ptv_pkg::ones4(turb_open_i & contact_valid) >= ptv_pkg::VOTE_MIN);
  assign fw_cond   = fw_enable_i && !flux_low &&
                     (ptv_pkg::ones4(fw_open_i[ptv_pkg::FW_PUMP1_LSB +: 4] & contact_valid)
                      >= ptv_pkg::VOTE_MIN) &&
                     (ptv_pkg::ones4(fw_open_i[ptv_pkg::FW_PUMP2_LSB +: 4] & contact_valid)
                      >= ptv_pkg::VOTE_MIN);
  assign bldg_cnt    = ptv_pkg::ones4(bldg_open_i & contact_valid);
  assign bldg_cond   = (bldg_cnt >= ptv_pkg::VOTE_MIN);
  assign bldg_single = (bldg_cnt == 3'h1);
  assign any_fault   = (|temp_fault_i) || (|press_fault_i) || (|link_lost_i) ||
                       (|peer_fault_i);

  // Function trips follow their condition each cycle, so they hold while it persists
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      temp_trip_reg  <= 1'b0;
      press_trip_reg <= 1'b0;
      pt_trip_reg    <= 1'b0;
      pump_trip_reg  <= 1'b0;
      turb_trip_reg  <= 1'b0;
      fw_trip_reg    <= 1'b0;
      bldg_trip_reg  <= 1'b0;
    end else begin
      temp_trip_reg  <= temp_cond;
      press_trip_reg <= press_cond;
      pt_trip_reg    <= pt_cond;
      pump_trip_reg  <= pump_cond;
      turb_trip_reg  <= turb_cond;
      fw_trip_reg    <= fw_cond;
      bldg_trip_reg  <= bldg_cond;
    end
  end

  // Channel trip; an online test trip from the service link joins in
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      chan_trip_reg <= 1'b0;
    end else begin
      chan_trip_reg <= temp_trip_reg | press_trip_reg | pt_trip_reg | pump_trip_reg |
                       turb_trip_reg | fw_trip_reg | bldg_trip_reg | svc_test_trip_reg;
    end
  end

  // Voter relays; a failed peer relay takes the configured fail state
  always_comb begin
    relay[0] = chan_trip_reg;
    for (int k = 1; k < ptv_pkg::CHANNELS; k++) begin
      relay[k] = peer_fault_i[k-1] ? fault_as_trip_i : peer_trip_i[k-1];
    end
  end
  assign vote = (ptv_pkg::ones4(relay) >= ptv_pkg::VOTE_MIN);

  // Relay output drives the breaker coil; registered to avoid glitches on it
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      trip_relay_output_o      <= 1'b0;
      rod_drive_breaker_trip_o <= 1'b0;
      rod_power_removed_o      <= 1'b0;
    end else begin
      trip_relay_output_o      <= vote;
      rod_drive_breaker_trip_o <= vote;
      rod_power_removed_o      <= (breaker_open_i[0] & breaker_open_i[1]) |
                                  (breaker_open_i[0] & breaker_open_i[3]) |
                                  (breaker_open_i[1] & breaker_open_i[2]) |
                                  (breaker_open_i[2] & breaker_open_i[3]);
    end
  end

  // Data shared with peers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      channel_trip_o <= 1'b0;
      turb_share_o   <= 1'b0;
      fw_share_o     <= 2'h0;
    end else begin
      channel_trip_o <= chan_trip_reg;
      turb_share_o   <= turb_open_i[0];
      fw_share_o     <= {fw_open_i[ptv_pkg::FW_PUMP2_LSB], fw_open_i[ptv_pkg::FW_PUMP1_LSB]};
    end
  end

  // Pump monitor results
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pump_count_o <= 3'h0;
      pump_loop_o  <= 2'h0;
    end else begin
      pump_count_o <= run_cnt;
      pump_loop_o  <= {|(running & ptv_pkg::LOOP_B_PUMPS), |(running & ptv_pkg::LOOP_A_PUMPS)};
    end
  end

  // Annunciation
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      alarm_o     <= '0;
      trouble_reg <= 1'b0;
    end else begin
      trouble_reg                  <= bldg_single | any_fault;
      alarm_o[ptv_pkg::ALM_TRIP]    <= chan_trip_reg;
      alarm_o[ptv_pkg::ALM_TROUBLE] <= bldg_single | any_fault;
      alarm_o[ptv_pkg::ALM_TEST]    <= |test_switch_i;
      alarm_o[ptv_pkg::ALM_FLUX_PSU] <= flux_psu_fail_i;
      alarm_o[ptv_pkg::ALM_SD_BYP]  <= shutdown_bypass_i;
      alarm_o[ptv_pkg::ALM_MAN_BYP] <= manual_bypass_i;
    end
  end

  // Outward data has no path back into the trip logic
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      plant_computer_o   <= '0;
      nonsafety_status_o <= '0;
    end else begin
      plant_computer_o <= ptv_pkg::STAT_W'({bldg_single, bldg_trip_reg, fw_trip_reg,
                          turb_trip_reg, pump_trip_reg, pt_trip_reg, press_trip_reg,
                          temp_trip_reg, trip_relay_output_o, alarm_o});
      nonsafety_status_o <= alarm_o;
    end
  end

  // Service link: reads status, one write bit forces an online test trip
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      service_ack_o     <= 1'b0;
      service_data_o    <= '0;
      svc_test_trip_reg <= 1'b0;
    end else begin
      service_ack_o <= service_valid_i;
      if (service_valid_i && service_write_i && service_sel_i == ptv_pkg::SVC_STATUS) begin
        svc_test_trip_reg <= service_wdata_i;
      end
      if (service_valid_i) begin
        case (service_sel_i)
          ptv_pkg::SVC_TEMP:  service_data_o <= {temp_sel.max2, temp_sel.min2};
          ptv_pkg::SVC_PRESS: service_data_o <= {press_sel.max2, press_sel.min2};
          ptv_pkg::SVC_PUMP:  service_data_o <= (2*W)'({pump_loop_o, pump_count_o});
          default:            service_data_o <= (2*W)'({trouble_reg, svc_test_trip_reg,
                                                         chan_trip_reg, alarm_o});
        endcase
      end
    end
  end

  // Checks
  AST_TEMP_TRIP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (temp_sel.ok && temp_sel.max2 > temp_hi_sp_i) |=> temp_trip_reg ##1 chan_trip_reg)
    else $error("temperature trip missing");
  AST_PRESS_TRIP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (press_sel.ok && press_sel.min2 < press_lo_sp_i) |=> press_trip_reg)
    else $error("low pressure trip missing");
  AST_VOTE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (ptv_pkg::ones4(relay) >= ptv_pkg::VOTE_MIN) |=> trip_relay_output_o)
    else $error("two channel vote did not trip");
  AST_NO_VOTE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (ptv_pkg::ones4(relay) < ptv_pkg::VOTE_MIN) |=> !trip_relay_output_o)
    else $error("trip relay held without vote");
  AST_FLUX_BYP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    flux_low |=> !turb_trip_reg && !fw_trip_reg)
    else $error("turbine or feedwater trip below startup flux");
  AST_BLDG_ONE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (ptv_pkg::ones4(bldg_open_i & contact_valid) == 3'h1) |=>
      !bldg_trip_reg && alarm_o[ptv_pkg::ALM_TROUBLE])
    else $error("single building contact handled wrongly");
  AST_ON_TEST: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (|test_switch_i) |=> alarm_o[ptv_pkg::ALM_TEST])
    else $error("on-test alarm not raised");
  AST_FAIL_TRIP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (peer_fault_i[0] && fault_as_trip_i && chan_trip_reg) |=> trip_relay_output_o)
    else $error("failed peer not counted as tripped");
  AST_LONE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (temp_sel.valid == ptv_pkg::LOCAL_MASK) |-> (temp_sel.max2 == temp_val_i[0]))
    else $error("lone local input not passed through");
  AST_ROD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (breaker_open_i[0] && breaker_open_i[3]) |=> rod_power_removed_o)
    else $error("rod power not removed for A and D");
endmodule
`default_nettype wire

// File: testbench/ptv_peer_model.sv
// Behavioural model of the three peer channels and the breaker row
`default_nettype none
module ptv_peer_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  // Bench commands
  input  wire logic [2:0] cmd_trip_i,
  input  wire logic [2:0] cmd_fault_i,
  input  wire logic [3:0] cmd_brk_i,
  input  wire logic       own_brk_trip_i,
  // Towards the channel
  output logic [2:0]      peer_trip_o,
  output logic [2:0]      peer_fault_o,
  output logic [3:0]      breaker_open_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Peer trips launched on the edge; a failed peer toggles its line
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      peer_trip_o  <= 3'h0;
      peer_fault_o <= 3'h0;
    end else begin
      peer_trip_o  <= (cmd_trip_i & ~cmd_fault_i) | (~peer_trip_o & cmd_fault_i);
      peer_fault_o <= cmd_fault_i;
    end
  end
  // Breaker A follows the own voter, the others stand in for peer voters
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      breaker_open_o <= 4'h0;
    end else begin
      breaker_open_o <= cmd_brk_i | {3'h0, own_brk_trip_i};
    end
  end
endmodule
`default_nettype wire

// File: testbench/test_protective_channel_trip_voting.sv
// Self-checking bench for the protective channel trip voter
`default_nettype none
module test_protective_channel_trip_voting;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int W   = 16;
  localparam int LAT = 5;  // Covers the three-edge trip pipeline
  typedef struct packed { logic [3:0] sel; logic [31:0] val; } ptv_note_t;
  // Stimulus and observed signals
  logic              ref_clk_i, reset_i, ten, fen, fat, psu, sdb, mb, sv, sw, sd;
  logic [3:0][W-1:0] tv, pv;
  logic [3:0]        tf, pf, ll, ps, turb, bldg, tsw, brk;
  logic [7:0]        fw;
  logic [W-1:0]      flux, tsp, phi, plo, bias, fsp;
  logic [2:0]        pmin, ctrip, cfault, ptrip, pfault;
  logic [1:0]        ssel, fws, ploop;
  logic [3:0]        bopen;
  logic              ack, ctr, tshare, relay, rodt, rodp;
  logic [2*W-1:0]    sdata;
  logic [2:0]        pcnt;
  logic [5:0]        alarm, nss;
  logic [15:0]       pc;
  ptv_note_t         notes[$];
  event              chk_ev;
  int                bad_count, compares;

  ptv_channel #(.W(W), .TEST_N(4)) ptv_channel_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .temp_val_i(tv), .temp_fault_i(tf),
    .press_val_i(pv), .press_fault_i(pf), .link_lost_i(ll), .flux_i(flux),
    .temp_hi_sp_i(tsp), .press_hi_sp_i(phi), .press_lo_sp_i(plo), .pt_bias_sp_i(bias),
    .flux_startup_sp_i(fsp), .pump_min_i(pmin), .turb_enable_i(ten), .fw_enable_i(fen),
    .pump_stop_i(ps), .turb_open_i(turb), .fw_open_i(fw), .bldg_open_i(bldg),
    .peer_trip_i(ptrip), .peer_fault_i(pfault), .fault_as_trip_i(fat), .breaker_open_i(bopen),
    .test_switch_i(tsw), .flux_psu_fail_i(psu), .shutdown_bypass_i(sdb),
    .manual_bypass_i(mb), .service_valid_i(sv), .service_write_i(sw), .service_sel_i(ssel),
    .service_wdata_i(sd), .service_ack_o(ack), .service_data_o(sdata),
    .channel_trip_o(ctr), .turb_share_o(tshare), .fw_share_o(fws),
    .trip_relay_output_o(relay), .rod_drive_breaker_trip_o(rodt),
    .rod_power_removed_o(rodp), .pump_count_o(pcnt), .pump_loop_o(ploop),
    .alarm_o(alarm), .plant_computer_o(pc), .nonsafety_status_o(nss));
  ptv_peer_model ptv_peer_model_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .cmd_trip_i(ctrip), .cmd_fault_i(cfault),
    .cmd_brk_i(brk), .own_brk_trip_i(rodt), .peer_trip_o(ptrip), .peer_fault_o(pfault),
    .breaker_open_o(bopen));

  // Free running clock
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] observe(input logic [3:0] s);
    case (s)
      4'h0: observe = 32'(ctr);
      4'h1: observe = {30'h0, rodt, relay};
      4'h2: observe = 32'(alarm);
      4'h3: observe = 32'(pc);
      4'h4: observe = {27'h0, ploop, pcnt};
      4'h5: observe = 32'(rodp);
      4'h6: observe = {29'h0, fws, tshare};
      4'h7: observe = sdata;
      4'h8: observe = 32'(nss);
      default: observe = 32'(ack);
    endcase
  endfunction
  // Second largest or smallest of the valid inputs; a lone one passes
  function automatic logic [W-1:0] pick2(input logic [3:0][W-1:0] v, input logic [3:0] ok,
                                         input logic hi);
    logic [W-1:0] q[$];
    for (int i = 0; i < 4; i++) if (ok[i]) q.push_back(v[i]);
    q.sort();
    if (q.size() == 1) return q[0];
    return hi ? q[q.size()-2] : q[1];
  endfunction
  task automatic expect_out(input logic [3:0] s, input logic [31:0] v);
    notes.push_back('{s, v});
    ->chk_ev;
  endtask
  task automatic settle();
    repeat (LAT) @(posedge ref_clk_i);
    #1;
  endtask
  // Quiet plant: nothing near a setpoint
  task automatic idle();
    tv = {4{16'h0064}}; pv = {4{16'h07d0}}; tf = 4'h0; pf = 4'h0; ll = 4'h0;
    flux = 16'h0; tsp = 16'h03e8; phi = 16'h0bb8; plo = 16'h0064; bias = 16'h0;
    fsp = 16'h0; pmin = 3'h0; ten = 1'b1; fen = 1'b1; ps = 4'h0; turb = 4'h0; fw = 8'h0;
    bldg = 4'h0; ctrip = 3'h0; cfault = 3'h0; fat = 1'b0; brk = 4'h0; tsw = 4'h0;
    psu = 1'b0; sdb = 1'b0; mb = 1'b0;
  endtask
  // One service request, held for exactly one taking edge
  task automatic svc(input logic wr, input logic [1:0] s, input logic d);
    sv = 1'b1; sw = wr; ssel = s; sd = d;
    @(posedge ref_clk_i);
    #1;
    sv = 1'b0;
    sw = 1'b0;
    expect_out(4'h9, 32'h1);
    @(posedge ref_clk_i);
    #1;
    expect_out(4'h9, 32'h0);
  endtask
  task automatic contact(input logic [3:0] t, input logic [7:0] f, input logic [3:0] b,
                         input logic [3:0] l, input logic [1:0] en, input logic sup,
                         input logic ex);
    idle();
    turb = t; fw = f; bldg = b; ll = l; ten = en[1]; fen = en[0];
    fsp = sup ? 16'h000a : 16'h0000;  // Flux 0 sits below a startup threshold of 10
    settle();
    expect_out(4'h0, 32'(ex));
    expect_out(4'h6, {29'h0, f[4], f[0], t[0]});
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Monitor: drains every queued note, oldest first, whenever a result is due
  initial forever begin
    @(chk_ev);
    while (notes.size() > 0) begin
      ptv_note_t n;
      n = notes.pop_front();
      compares++;
      if (observe(n.sel) !== n.val) begin
        bad_count++;
        $display("[FAIL] %0t group %0d got %h want %h", $time, n.sel, observe(n.sel), n.val);
      end
    end
  end
  // Watchdog, far beyond the few thousand cycles the tests need
  initial begin
    #160000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end

  // Main sequence
  initial begin
    logic [W-1:0] m;
    logic         e;
    idle();
    {sv, sw, sd, ssel} = 5'h0;
    reset_i = 1'b1;
    void'($urandom(76604));
    repeat (16) @(posedge ref_clk_i);
    #1;
    expect_out(4'h0, 32'h0);
    expect_out(4'h1, 32'h0);
    reset_i = 1'b0;
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++) tv[i] = 16'(1 + $urandom_range(998));
      m = pick2(tv, 4'hf, 1'b1);
      tsp = m; settle();
      expect_out(4'h0, 32'h0);
      tsp = m - 16'h1; settle();
      expect_out(4'h0, 32'h1);
      expect_out(4'h2, 32'h1);
    end
    tsp = 16'h03e8; settle();
    expect_out(4'h0, 32'h0);
    // Excluded inputs: v0=900 local, v1=800, setpoint 850
    tv = {16'h0064, 16'h0064, 16'h0320, 16'h0384}; tsp = 16'h0352;
    tf = 4'h2; settle(); expect_out(4'h0, 32'h0);
    tf = 4'h0; ll = 4'hc; settle(); expect_out(4'h0, 32'h0);
    ll = 4'hf; settle(); expect_out(4'h0, 32'h1);
    ll = 4'h0; tf = 4'hf; settle(); expect_out(4'h0, 32'h1);
    idle();
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 4; i++) pv[i] = 16'($urandom_range(2800, 200));
      m = pick2(pv, 4'hf, 1'b1);
      phi = m; settle(); expect_out(4'h0, 32'h0);
      phi = m - 16'h1; settle(); expect_out(4'h0, 32'h1);
      phi = 16'h0bb8; m = pick2(pv, 4'hf, 1'b0);
      plo = m; settle(); expect_out(4'h0, 32'h0);
      plo = m + 16'h1; settle(); expect_out(4'h0, 32'h1);
      plo = 16'h0064;
      bias = m - 16'h0064; settle(); expect_out(4'h0, 32'h0);
      bias = m - 16'h0063; settle(); expect_out(4'h0, 32'h1);
      bias = 16'h0;
    end
    contact(4'h1, 8'h00, 4'h0, 4'h0, 2'h3, 1'b0, 1'b0);
    contact(4'h3, 8'h00, 4'h0, 4'h0, 2'h3, 1'b0, 1'b1);
    contact(4'h3, 8'h00, 4'h0, 4'h0, 2'h1, 1'b0, 1'b0);
    contact(4'h3, 8'h00, 4'h0, 4'h0, 2'h3, 1'b1, 1'b0);
    contact(4'h3, 8'h00, 4'h0, 4'h2, 2'h3, 1'b0, 1'b0);
    contact(4'h7, 8'h00, 4'h0, 4'h2, 2'h3, 1'b0, 1'b1);
    contact(4'h0, 8'h03, 4'h0, 4'h0, 2'h3, 1'b0, 1'b0);
    contact(4'h0, 8'h33, 4'h0, 4'h0, 2'h3, 1'b0, 1'b1);
    contact(4'h0, 8'h33, 4'h0, 4'h0, 2'h2, 1'b0, 1'b0);
    contact(4'h0, 8'h33, 4'h0, 4'h0, 2'h3, 1'b1, 1'b0);
    contact(4'h0, 8'h00, 4'h5, 4'h0, 2'h3, 1'b0, 1'b1);
    contact(4'h0, 8'h00, 4'h4, 4'h0, 2'h3, 1'b0, 1'b0);
    expect_out(4'h2, 32'h2);
    expect_out(4'h3, 32'h4002);
    idle();
    for (int k = 0; k < 6; k++) begin
      ps = 4'($urandom);
      pmin = 3'($urandom_range(4));  // Pump trip below a random running minimum
      settle();
      expect_out(4'h0, 32'((4 - $countones(ps)) < pmin));
      expect_out(4'h4, {27'h0, ~&ps[3:2], ~&ps[1:0], 3'(4 - $countones(ps))});
    end
    svc(1'b0, 2'h3, 1'b0);
    expect_out(4'h7, {27'h0, ~&ps[3:2], ~&ps[1:0], 3'(4 - $countones(ps))});
    ps = 4'h0;
    for (int k = 0; k < 6; k++) begin
      tsw = 4'($urandom); {mb, sdb, psu} = 3'($urandom); settle();
      expect_out(4'h2, {26'h0, mb, sdb, psu, |tsw, 2'h0});
      expect_out(4'h8, {26'h0, mb, sdb, psu, |tsw, 2'h0});
    end
    idle();
    svc(1'b1, 2'h1, 1'b1); settle();
    expect_out(4'h0, 32'h0);
    expect_out(4'h7, 32'h00640064);
    svc(1'b0, 2'h2, 1'b0);
    expect_out(4'h7, 32'h07d007d0);
    for (int own = 0; own < 2; own++) begin
      svc(1'b1, 2'h0, 1'(own));
      for (int a = 0; a < 32; a++) begin
        fat = a[4];
        for (int p = 0; p < 8; p++) begin
          ctrip = 3'(p); cfault = a[2:0]; settle();
          e = (own + $countones((ctrip & ~cfault) | (cfault & {3{fat}}))) >= 2;
          expect_out(4'h1, {30'h0, e, e});
        end
      end
    end
    idle();
    settle();
    expect_out(4'h0, 32'h1);
    reset_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    expect_out(4'h1, 32'h0);
    reset_i = 1'b0;
    settle();
    expect_out(4'h0, 32'h0);
    for (int b = 0; b < 16; b++) begin
      brk = 4'(b); settle();
      expect_out(4'h5, 32'((brk[0] | brk[2]) & (brk[1] | brk[3])));
    end
    #1;
    wrap_up();
  end
endmodule
`default_nettype wire
